/* design/range_type_defines.svh */
// Register indices, field positions, encodings and counts of the range-type block
`ifndef RANGE_TYPE_DEFINES_SVH
`define RANGE_TYPE_DEFINES_SVH
`define RT_UC 8'h00
`define RT_WC 8'h01
`define RT_WT 8'h04
`define RT_WP 8'h05
`define RT_WB 8'h06
`define RT_IDX_W 8
`define RT_IDX_CAP 8'h01
`define RT_IDX_DEF 8'h02
`define RT_IDX_FIX_FIRST 8'h10
`define RT_IDX_FIX_LAST 8'h1a
`define RT_CAP_VALUE 64'h0000_0000_0000_0508
`define RT_CAP_FIX_BIT 8
`define RT_CAP_WC_BIT 10
`define RT_DEF_TYPE_LSB 0
`define RT_DEF_FE_BIT 10
`define RT_DEF_E_BIT 11
`define RT_DEF_RESV_MASK 64'hffff_ffff_ffff_f300
`define RT_DEF_RESET 12'h000
`define RT_FEATURE_BIT 12
`define RT_PHYS_W 36
`define RT_FIX_TOP_BIT 20
`define RT_RANGE_TOTAL 96
`define RT_FIX_REGS 11
`define RT_VAR_RANGES 8
`define RT_LATENCY 2
`endif

/* design/range_type_pkg.sv */
// Types shared by the range-type block
package range_type_pkg;
`include "range_type_defines.svh"
    typedef enum logic [7:0] {
        UNCACHEABLE     = `RT_UC,
        WRITE_COMBINING = `RT_WC,
        WRITE_THROUGH   = `RT_WT,
        WRITE_PROTECTED = `RT_WP,
        WRITE_BACK      = `RT_WB
    } memType_t;

    // One model-specific register operation
    typedef struct packed {
        logic                 rd;
        logic                 wr;
        logic [`RT_IDX_W-1:0] index;
        logic [63:0]          wdata;
    } regReq_t;

    // One address to type, with the variable-range match result beside it
    typedef struct packed {
        logic                  valid;
        logic [`RT_PHYS_W-1:0] addr;
        logic                  varHit;
        logic [7:0]            varType;
    } lookupReq_t;

    // True for the five codes that name a memory type
    function automatic logic legalType(input logic [7:0] code);
        return (code == UNCACHEABLE) || (code == WRITE_COMBINING) || (code == WRITE_THROUGH)
            || (code == WRITE_PROTECTED) || (code == WRITE_BACK);
    endfunction
endpackage

/* design/fixed_type_store.sv */
// Storage of the fixed-range type registers, two registered read ports
`timescale 1ns/1ps
module fixed_type_store #(
    parameter int DEPTH = 11,
    parameter int WIDTH = 64,
    parameter int AW    = 4
) (
    input  wire logic             mclk,
    input  wire logic             rstSyncN,
    input  wire logic             ce,
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [AW-1:0]    rdAddrA,
    output logic      [WIDTH-1:0] rdDataA,
    input  wire logic [AW-1:0]    rdAddrB,
    output logic      [WIDTH-1:0] rdDataB
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Entries clear at reset so nothing unknown is ever read back
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= '0;
        end
        else if (ce && wrEn)
            mem[wrAddr] <= wrData;
    end

    // Registered reads; out-of-range addresses read zero
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            rdDataA <= '0;
            rdDataB <= '0;
        end
        else if (ce)
        begin
            rdDataA <= (32'(rdAddrA) < DEPTH) ? mem[rdAddrA] : '0;
            rdDataB <= (32'(rdAddrB) < DEPTH) ? mem[rdAddrB] : '0;
        end
    end
endmodule

/* design/memory_type_range_lookup.sv */
// Memory-type range registers and per-address type resolution
//
// Behaviour
// - At most 96 ranges: 88 fixed sub-ranges plus 8 variable ranges.
// - Reset clears the enables, so every address resolves uncacheable.
// - Type codes: UC 00, WC 01, WT 04, WP 05, WB 06.
// - Writing a reserved type code into any type field faults.
// - Feature word bit 12 reports that range typing exists.
// - Capability register is read-only; writing it faults.
// - Capability bits 7:0 give variable range count, eight here.
// - Capability bit 8 reads one: fixed ranges are implemented.
// - Capability bit 10 reads one: write-combining is supported.
// - Capability register always reads 508H.
// - Default type field accepts only 0,1,4,5,6; others fault.
// - Fixed enable bit 10 turns fixed ranges on; they beat variable ranges.
// - With fixed ranges off, variable ranges may cover the first megabyte.
// - Global enable bit 11 clear forces uncacheable everywhere, ignoring fixed enable.
// - Enabled, unmatched addresses take the default type field.
// - Nonzero writes to default register bits 8, 9, 12-63 fault.
// - Eleven 64-bit fixed registers, eight 8-bit type fields each.
// - First fixed register types 0-7FFFFH in 64 KByte pieces.
// - Two registers type 80000-BFFFFH in 16 KByte pieces.
// - Eight registers type C0000-FFFFFH in 4 KByte pieces, ascending.
// - Lowest sub-range uses bits 7:0, highest bits 63:56.
`timescale 1ns/1ps
`include "range_type_defines.svh"
module memory_type_range_lookup #(
    parameter int VAR_RANGES = `RT_VAR_RANGES,
    parameter int FIX_REGS   = `RT_FIX_REGS
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire range_type_pkg::regReq_t    regReq,
    output logic      [63:0]                readData,
    output logic                            regDone,
    output logic                            regFault,
    output logic      [31:0]                featureInfo,
    input  wire range_type_pkg::lookupReq_t lookupReq,
    output logic      [7:0]                 lookupType,
    output logic                            lookupDone,
    output logic                            rangesEnabled
);
    import range_type_pkg::*;

    localparam int FIX_FIELDS = FIX_REGS * 8;

    logic        rstMeta;
    logic        rstSyncN;
    logic [11:0] defReg;
    logic [7:0]  byteOk;
    logic        isCap;
    logic        isDef;
    logic        isFix;
    logic [3:0]  fixIdx;
    logic        wrFault;
    logic        rdFault;
    logic        doWrite;
    logic        doRead;
    logic [63:0] capWord;
    logic [63:0] fixRead;
    logic [63:0] fixLook;
    logic [3:0]  lookEntry;
    logic [2:0]  lookByte;
    logic        lookInFix;
    logic        s1Done;
    logic        s1Fault;
    logic        s1FromFix;
    logic [63:0] s1Data;
    logic        l1Valid;
    logic        l1InFix;
    logic [2:0]  l1Byte;
    logic        l1VarHit;
    logic [7:0]  l1VarType;
    logic [11:0] l1Def;
    logic [7:0]  next_lookupType;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end
        else
        begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // Capability word assembled from its fields
    assign capWord = 64'(VAR_RANGES) | (64'h1 << `RT_CAP_FIX_BIT) | (64'h1 << `RT_CAP_WC_BIT);

    // Index decode
    assign isCap  = (regReq.index == `RT_IDX_CAP);
    assign isDef  = (regReq.index == `RT_IDX_DEF);
    assign isFix  = (regReq.index >= `RT_IDX_FIX_FIRST) && (regReq.index <= `RT_IDX_FIX_LAST);
    assign fixIdx = 4'(regReq.index - `RT_IDX_FIX_FIRST);

    // Legality of each written type byte
    for (genvar i = 0; i < 8; i++)
    begin : g_byteCheck
        assign byteOk[i] = legalType(regReq.wdata[8*i +: 8]);
    end

    // Fault decision for a write or a read
    always_comb
    begin
        wrFault = 1'b1;
        if (isCap)
            wrFault = 1'b1;
        else if (isDef)
            wrFault = !byteOk[0] || ((regReq.wdata & `RT_DEF_RESV_MASK) != 64'h0);
        else if (isFix)
            wrFault = !(&byteOk);
    end
    assign rdFault = !(isCap || isDef || isFix);
    assign doWrite = regReq.wr && !wrFault;
    assign doRead  = regReq.rd && !regReq.wr;

    // Default-type register; reset leaves all ranges off
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            defReg <= `RT_DEF_RESET;
        else if (ce && doWrite && isDef)
            defReg <= regReq.wdata[11:0];
    end

    // Fixed-range storage; a faulting write stores nothing
    fixed_type_store #(
        .DEPTH (FIX_REGS),
        .WIDTH (64),
        .AW    (4)
    ) u_store (
        .mclk     (mclk),
        .rstSyncN (rstSyncN),
        .ce       (ce),
        .wrEn     (doWrite && isFix),
        .wrAddr   (fixIdx),
        .wrData   (regReq.wdata),
        .rdAddrA  (fixIdx),
        .rdDataA  (fixRead),
        .rdAddrB  (lookEntry),
        .rdDataB  (fixLook)
    );

    // First register stage of an operation
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            s1Done    <= 1'b0;
            s1Fault   <= 1'b0;
            s1FromFix <= 1'b0;
            s1Data    <= 64'h0;
        end
        else if (ce)
        begin
            s1Done    <= regReq.wr || regReq.rd;
            s1Fault   <= regReq.wr ? wrFault : (regReq.rd && rdFault);
            s1FromFix <= doRead && isFix;
            s1Data    <= !doRead ? 64'h0 : isCap ? capWord : isDef ? {52'h0, defReg} : 64'h0;
        end
    end

    // Answer stage: read data, completion and fault
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            readData <= 64'h0;
            regDone  <= 1'b0;
            regFault <= 1'b0;
        end
        else if (ce)
        begin
            readData <= s1FromFix ? fixRead : s1Data;
            regDone  <= s1Done;
            regFault <= s1Fault;
        end
    end

    // Feature word with the range-typing flag, and the global enable status
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            featureInfo   <= 32'h0;
            rangesEnabled <= 1'b0;
        end
        else if (ce)
        begin
            featureInfo   <= 32'h1 << `RT_FEATURE_BIT;
            rangesEnabled <= defReg[`RT_DEF_E_BIT];
        end
    end

    // Map an address below one megabyte to its register and byte
    always_comb
    begin
        lookInFix = (lookupReq.addr[`RT_PHYS_W-1:`RT_FIX_TOP_BIT] == '0);
        if (!lookupReq.addr[19])
        begin
            lookEntry = 4'h0;
            lookByte  = lookupReq.addr[18:16];
        end
        else if (!lookupReq.addr[18])
        begin
            lookEntry = {3'h0, lookupReq.addr[17]} + 4'h1;
            lookByte  = lookupReq.addr[16:14];
        end
        else
        begin
            lookEntry = {1'b0, lookupReq.addr[17:15]} + 4'h3;
            lookByte  = lookupReq.addr[14:12];
        end
    end

    // First lookup stage, with a snapshot of the enables
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            l1Valid   <= 1'b0;
            l1InFix   <= 1'b0;
            l1Byte    <= 3'h0;
            l1VarHit  <= 1'b0;
            l1VarType <= 8'h00;
            l1Def     <= `RT_DEF_RESET;
        end
        else if (ce)
        begin
            l1Valid   <= lookupReq.valid;
            l1InFix   <= lookInFix;
            l1Byte    <= lookByte;
            l1VarHit  <= lookupReq.varHit;
            l1VarType <= lookupReq.varType;
            l1Def     <= defReg;
        end
    end

    // Resolve the type by priority
    always_comb
    begin
        if (!l1Def[`RT_DEF_E_BIT])
            next_lookupType = UNCACHEABLE;
        else if (l1Def[`RT_DEF_FE_BIT] && l1InFix)
            next_lookupType = fixLook[8*l1Byte +: 8];
        else if (l1VarHit)
            next_lookupType = l1VarType;
        else
            next_lookupType = l1Def[7:0];
    end

    // Lookup answer register
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            lookupType <= UNCACHEABLE;
            lookupDone <= 1'b0;
        end
        else if (ce)
        begin
            lookupType <= next_lookupType;
            lookupDone <= l1Valid;
        end
    end

    a_range_total: assert property (@(posedge mclk) disable iff (!rstSyncN)
        FIX_FIELDS + VAR_RANGES <= `RT_RANGE_TOTAL)
        else $error("range count above limit");

    a_reset_off: assert property (@(posedge mclk) disable iff (!rstSyncN)
        !$past(rstSyncN) |-> !defReg[`RT_DEF_E_BIT] && !defReg[`RT_DEF_FE_BIT])
        else $error("enables set after reset");

    a_feature_flag: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && $past(ce) |=> featureInfo[`RT_FEATURE_BIT])
        else $error("feature flag missing");

    a_cap_read_value: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && regReq.rd && !regReq.wr && isCap ##1 ce ##1 ce |-> readData == `RT_CAP_VALUE && regDone && !regFault)
        else $error("capability read wrong");

    a_cap_write_fault: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && regReq.wr && isCap ##1 ce ##1 ce |-> regFault && regDone)
        else $error("capability write not faulted");

    a_def_bad_type: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && regReq.wr && isDef && !legalType(regReq.wdata[7:0]) |=> defReg == $past(defReg))
        else $error("illegal default type stored");

    a_def_reserved: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && regReq.wr && isDef && (regReq.wdata & `RT_DEF_RESV_MASK) != 64'h0 ##1 ce ##1 ce |-> regFault)
        else $error("reserved write not faulted");

    a_fixed_bad_byte: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && regReq.wr && isFix && !(&byteOk) ##1 ce ##1 ce |-> regFault)
        else $error("bad fixed byte not faulted");

    a_disabled_uc: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && lookupReq.valid && !defReg[`RT_DEF_E_BIT] ##1 ce ##1 ce |-> lookupDone && lookupType == `RT_UC)
        else $error("disabled lookup not uncacheable");

    a_var_fix_off: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && lookupReq.valid && defReg[`RT_DEF_E_BIT] && !defReg[`RT_DEF_FE_BIT] && lookupReq.varHit
        ##1 ce ##1 ce |-> lookupType == $past(lookupReq.varType, 2))
        else $error("variable type not used");

    a_default_type: assert property (@(posedge mclk) disable iff (!rstSyncN)
        ce && lookupReq.valid && defReg[`RT_DEF_E_BIT] && !lookupReq.varHit
        && !(defReg[`RT_DEF_FE_BIT] && lookInFix) ##1 ce ##1 ce |-> lookupType == $past(defReg[7:0], 2))
        else $error("default type not used");
endmodule

/* tb/memory_type_range_lookup_tb.sv */
// Self-checking bench for the memory-type range lookup block
`timescale 1ns/1ps
module memory_type_range_lookup_tb;
    import range_type_pkg::*;
    logic        mclk;
    logic        rst_n;
    logic        ce;
    regReq_t     regReq;
    logic [63:0] readData;
    logic        regDone;
    logic        regFault;
    logic [31:0] featureInfo;
    lookupReq_t  lookupReq;
    logic [7:0]  lookupType;
    logic        lookupDone;
    logic        rangesEnabled;
    int          failures;
    int          total_checks;
    logic [31:0] seed;
    logic [63:0] defModel;
    logic [63:0] fixModel [11];
    logic [7:0]  codes [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
    logic [7:0]  badCodes [4] = '{8'h02, 8'h03, 8'h07, 8'hff};
    logic [35:0] edges [7] = '{36'h0, 36'h7ffff, 36'h80000, 36'hbffff, 36'hc0000, 36'hfffff, 36'h100000};

    memory_type_range_lookup u_memory_type_range_lookup (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .ce            (ce),
        .regReq        (regReq),
        .readData      (readData),
        .regDone       (regDone),
        .regFault      (regFault),
        .featureInfo   (featureInfo),
        .lookupReq     (lookupReq),
        .lookupType    (lookupType),
        .lookupDone    (lookupDone),
        .rangesEnabled (rangesEnabled)
    );

    // Free-running core clock, 8 ns period
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Xorshift source for stimulus
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Bench's own view of a legal type code
    function automatic logic isLegal(input logic [7:0] c);
        return c == 8'h00 || c == 8'h01 || c == 8'h04 || c == 8'h05 || c == 8'h06;
    endfunction

    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Wait for a done flag; it is registered at the first edge after the taking edge,
    // so polling just after edges sees it after the first one
    task automatic waitDone(input logic isLookup);
        int n;
        n = 0;
        while ((isLookup ? lookupDone : regDone) !== 1'b1 && n < 4)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 4)
        begin
            failures++;
            finish_test();
        end
        check(64'(n), 64'd1, "answer latency");
    endtask

    // One register operation, held for its taking edge only
    task automatic regOp(input logic wr, input logic [7:0] idx, input logic [63:0] wdata,
                         input logic [63:0] expData, input logic expFault);
        regReq.rd = ~wr;
        regReq.wr = wr;
        regReq.index = idx;
        regReq.wdata = wdata;
        @(posedge mclk);
        #1;
        regReq.rd = 1'b0;
        regReq.wr = 1'b0;
        waitDone(1'b0);
        check(readData, expData, "read data");
        check(64'(regFault), 64'(expFault), "fault flag");
    endtask

    task automatic rdReg(input logic [7:0] idx);
        logic [63:0] exp;
        logic        flt;
        flt = 1'b0;
        exp = 64'h0;
        if (idx == 8'h01)
            exp = 64'h508;
        else if (idx == 8'h02)
            exp = defModel;
        else if (idx >= 8'h10 && idx <= 8'h1a)
            exp = fixModel[idx - 8'h10];
        else
            flt = 1'b1;
        regOp(1'b0, idx, 64'h0, exp, flt);
    endtask

    task automatic wrReg(input logic [7:0] idx, input logic [63:0] d);
        logic flt;
        flt = 1'b0;
        if (idx == 8'h02)
            flt = !isLegal(d[7:0]) || (d & 64'hffff_ffff_ffff_f300) != 64'h0;
        else if (idx >= 8'h10 && idx <= 8'h1a)
        begin
            for (int k = 0; k < 8; k++)
                if (!isLegal(d[k*8 +: 8]))
                    flt = 1'b1;
        end
        else
            flt = 1'b1;
        if (!flt && idx == 8'h02)
            defModel = d;
        if (!flt && idx >= 8'h10)
            fixModel[idx - 8'h10] = d;
        regOp(1'b1, idx, d, 64'h0, flt);
    endtask

    // Resolve one address in the bench model and compare
    task automatic lookup(input logic [35:0] addr, input logic hit, input logic [7:0] vt);
        logic [7:0] exp;
        int         r;
        int         b;
        if (!defModel[11])
            exp = 8'h00;
        else if (defModel[10] && addr < 36'h100000)
        begin
            r = 0;
            b = int'(addr[18:16]);
            if (addr >= 36'hc0000)
            begin
                r = 3 + int'((addr - 36'hc0000) >> 15);
                b = int'(addr[14:12]);
            end
            else if (addr >= 36'h80000)
            begin
                r = 1 + int'((addr - 36'h80000) >> 17);
                b = int'(addr[16:14]);
            end
            exp = fixModel[r][b*8 +: 8];
        end
        else if (hit)
            exp = vt;
        else
            exp = defModel[7:0];
        lookupReq = '{valid: 1'b1, addr: addr, varHit: hit, varType: vt};
        @(posedge mclk);
        #1;
        lookupReq.valid = 1'b0;
        waitDone(1'b1);
        check(64'(lookupType), 64'(exp), "lookup type");
    endtask

    task automatic doReset();
        rst_n = 1'b0;
        defModel = 64'h0;
        foreach (fixModel[i])
            fixModel[i] = 64'h0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // Main sequence
    initial
    begin
        logic [63:0] d;
        failures = 0;
        total_checks = 0;
        seed = 32'd73962;
        ce = 1'b1;
        regReq = '0;
        lookupReq = '0;
        doReset();
        check(64'(featureInfo), 64'h1000, "feature word");
        check(64'(rangesEnabled), 64'h0, "enable copy");
        rdReg(8'h01);
        rdReg(8'h02);
        lookup(36'hc1000, 1'b1, 8'h06);
        wrReg(8'h01, 64'h0);
        rdReg(8'h01);
        for (int c = 0; c < 9; c++)
        begin
            wrReg(8'h02, 64'h800 | 64'(c));
            rdReg(8'h02);
        end
        wrReg(8'h02, 64'h8ff);
        foreach (edges[i])
            wrReg(8'h02, 64'h806 | (64'h1 << (i == 0 ? 8 : (i == 1 ? 9 : 5 + i * 8))));
        rdReg(8'h02);
        for (int i = 0; i < 11; i++)
        begin
            for (int k = 0; k < 8; k++)
                d[k*8 +: 8] = codes[rnd() % 5];
            wrReg(8'h10 + 8'(i), d);
            d[(rnd() % 8) * 8 +: 8] = badCodes[rnd() % 4];
            wrReg(8'h10 + 8'(i), d);
            rdReg(8'h10 + 8'(i));
        end
        rdReg(8'h00);
        rdReg(8'h1b);
        for (int m = 0; m < 4; m++)
        begin
            wrReg(8'h02, {52'h0, 1'(m >> 1), 1'(m), 2'b00, codes[rnd() % 5]});
            check(64'(rangesEnabled), 64'(defModel[11]), "enable copy");
            foreach (edges[i])
                lookup(edges[i], 1'(rnd()), 8'h01);
            for (int j = 0; j < 40; j++)
            begin
                d = 64'(rnd());
                lookup(j[0] ? 36'(d[19:0]) : {d[31:0], 4'h0}, d[20], codes[d[23:21] % 5]);
            end
        end
        // Clock enable low: a legal write presented meanwhile is never taken
        ce = 1'b0;
        regReq = '{rd: 1'b0, wr: 1'b1, index: 8'h02, wdata: 64'h405};
        repeat (3) @(posedge mclk);
        #1;
        check(64'(regDone), 64'h0, "frozen done");
        regReq.wr = 1'b0;
        ce = 1'b1;
        rdReg(8'h02);
        doReset();
        rdReg(8'h02);
        rdReg(8'h13);
        lookup(36'h0, 1'b1, 8'h06);
        finish_test();
    end
endmodule
